// ==== rtl/tgw_pkg.sv ====
/*
  tgw_pkg: shared constants and types of the transmit gate wake-up block.
  assumes: one clock (the converter sample clock) and a 32-bit register bus.
*/
package tgw_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [3:0]  TGW_OFS_CTRL  = 4'h0;   // delay setting and power-down mask
  localparam logic [3:0]  TGW_OFS_STAT  = 4'h4;   // live state of the gate logic

  // ==========================================================
  // control register fields
  localparam int          TGW_PD_LSB    = 0;      // power-down mask, low bit
  localparam int          TGW_PD_W      = 5;      // cores, fifo, filters, pll, reference
  localparam int          TGW_DLY0_BIT  = 5;      // extended delay 0 (value 0x20)
  localparam int          TGW_DLY1_BIT  = 6;      // extended delay 1 (value 0x60)
  localparam logic [6:0]  TGW_CTRL_RST  = 7'h00;  // no extended delay, nothing powered down

  // ==========================================================
  // status register fields
  localparam int          TGW_ST_ACT_BIT  = 0;    // outputs transmitting
  localparam int          TGW_ST_CLP_BIT  = 1;    // clamped by a falling edge
  localparam int          TGW_ST_WAIT_BIT = 2;    // wake-up wait running
  localparam int          TGW_ST_PIN_BIT  = 3;    // synchronised pin level
  localparam int          TGW_ST_PD_LSB   = 4;    // power-down outputs
  localparam int          TGW_ST_CNT_LSB  = 16;   // divided-edge counter

  // ==========================================================
  // timing
  localparam int          TGW_DIV_RATIO  = 64;    // wake counter rate divider
  localparam int          TGW_FIX_CYC    = 10;    // fixed converter clocks after the count
  localparam int          TGW_EDGES_NONE = 1;     // divided edges, no extended delay
  localparam int          TGW_EDGES_EXT0 = 12;    // divided edges, extended delay 0
  localparam int          TGW_EDGES_EXT1 = 19;    // divided edges, extended delay 1
  localparam int          TGW_PRIME_CYC  = 3;     // cycles before pin edges are believed
  localparam logic [15:0] TGW_MIDSCALE   = 16'h8000; // offset-binary midscale code

  // ==========================================================
  // gate state machine
  typedef enum logic [1:0] {
    TGW_ST_RUN,
    TGW_ST_CLAMP,
    TGW_ST_WAIT_DIV,
    TGW_ST_WAIT_FIX
  } tgw_state_t;

endpackage : tgw_pkg

// ==== rtl/tgw_tick_if.sv ====
/*
  tgw_tick_if: carries the divided-rate enable pulse from the divider to the gate.
  assumes: both ends on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

interface tgw_tick_if;
  logic tick;  // one-cycle pulse, once per divider period

  modport src (output tick);
  modport snk (input  tick);
endinterface : tgw_tick_if

`default_nettype wire

// ==== rtl/tgw_div.sv ====
/*
  tgw_div: free-running divider that pulses an enable once every RATIO clocks.
  assumes: clk_sys is the converter clock; synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module tgw_div #(
  parameter int RATIO = tgw_pkg::TGW_DIV_RATIO
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // divided-rate enable
  tgw_tick_if.src   tk
);
  import tgw_pkg::*;

  localparam int CW = (RATIO > 1) ? $clog2(RATIO) : 1;
  localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

  // a ratio below two leaves no room for a pulse between pulses
  if (RATIO < 2)
  begin : g_bad_ratio
    $error("tgw_div: RATIO must be at least 2");
  end

  logic [CW-1:0] cnt_r;   // position within the period
  logic          tick_r;  // registered pulse

  // ==========================================================
  // period counter, wraps at RATIO
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cnt_r <= '0;
    else if (cnt_r == LAST)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + CW'(1);
  end

  // pulse decoded from the last count, high on count zero, so each period gives one edge
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      tick_r <= 1'b0;
    else
      tick_r <= (cnt_r == LAST);
  end

  assign tk.tick = tick_r;

  // pulses stay exactly RATIO apart
  a_tick_spacing: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick_r |-> (cnt_r == '0))
  else $error("divided pulse out of phase with its counter");

endmodule : tgw_div

`default_nettype wire

// ==== rtl/tgw_gate.sv ====
/*
  tgw_gate: transmit gate wake-up logic with an Avalon-MM register slave.
  assumes: clk_sys is the converter sample clock; the gate pin is asynchronous;
  the controller holds the pin high through power-up.
*/
`timescale 1ns/1ps
`default_nettype none

module tgw_gate (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // avalon-mm register slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // transmit gate pin from the controller
  input  wire logic        transmit_gate_pin,
  // datapath in and converter outputs
  input  wire logic [15:0] dac_i_in,
  input  wire logic [15:0] dac_q_in,
  output logic      [15:0] dac_i_out,
  output logic      [15:0] dac_q_out,
  output logic             tx_active,
  // block power-down requests
  output logic      [tgw_pkg::TGW_PD_W-1:0] pd_out
);
  import tgw_pkg::*;

  localparam int WAKE_MAX = (TGW_EDGES_EXT1 + 1) * TGW_DIV_RATIO + TGW_FIX_CYC + 4;

  // ==========================================================
  // declarations
  tgw_tick_if tk_if ();                  // divided-rate enable

  logic              pin_s1_r;          // synchroniser stage one
  logic              pin_s2_r;          // synchroniser stage two
  logic              pin_d_r;           // previous synchronised level
  logic [1:0]        prime_r;           // settle count after reset
  logic              primed_r;          // edges are trusted
  logic              fall;              // falling edge seen
  logic              rise;              // rising edge seen
  tgw_state_t        state_r;           // gate state
  tgw_state_t        state_nxt;
  logic [4:0]        div_cnt_r;         // divided edges counted
  logic [4:0]        target_r;          // divided edges to wait
  logic [3:0]        fix_cnt_r;         // fixed converter clocks counted
  logic [6:0]        ctrl_r;            // control register
  logic [31:0]       rdata_r;           // read data
  logic              wait_r;            // waitrequest
  logic [15:0]       i_out_r;
  logic [15:0]       q_out_r;
  logic              act_r;
  logic [TGW_PD_W-1:0] pd_r;
  logic [11:0]       wake_cyc_r;        // helper: cycles since rise
  logic              req;
  logic              div_done;
  logic              fix_done;

  // ==========================================================
  // divider for the wake counter
  tgw_div #(.RATIO(TGW_DIV_RATIO)) u_div (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .tk      (tk_if.src)
  );

  // ==========================================================
  // pin synchroniser and edge detect
  // two flops before anything looks at the asynchronous pin
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= transmit_gate_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  // previous level, tracked even while priming
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pin_d_r <= 1'b0;
    else
      pin_d_r <= pin_s2_r;
  end

  // ignore edges until the synchroniser holds real samples, so a pin
  // already low at power-up never looks like a falling edge
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      prime_r  <= '0;
      primed_r <= 1'b0;
    end
    else if (!primed_r)
    begin
      prime_r  <= prime_r + 2'd1;
      primed_r <= (prime_r == 2'(TGW_PRIME_CYC - 1));
    end
  end

  assign fall = primed_r && pin_d_r && !pin_s2_r;
  assign rise = primed_r && !pin_d_r && pin_s2_r;

  // ==========================================================
  // gate state machine
  assign div_done = tk_if.tick && (div_cnt_r == target_r - 5'd1);
  assign fix_done = (fix_cnt_r == 4'(TGW_FIX_CYC - 1));

  // a fall anywhere wins: clamps, or abandons a running wait
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      TGW_ST_RUN:      if (fall) state_nxt = TGW_ST_CLAMP;
      TGW_ST_CLAMP:    if (rise) state_nxt = TGW_ST_WAIT_DIV;
      TGW_ST_WAIT_DIV:
      begin
        if (fall)
          state_nxt = TGW_ST_CLAMP;
        else if (div_done)
          state_nxt = TGW_ST_WAIT_FIX;
      end
      TGW_ST_WAIT_FIX:
      begin
        if (fall)
          state_nxt = TGW_ST_CLAMP;
        else if (fix_done)
          state_nxt = TGW_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      state_r <= TGW_ST_RUN;
    else
      state_r <= state_nxt;
  end

  // latch the edge target on the rise; a write mid-wait does not move it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      target_r <= 5'(TGW_EDGES_NONE);
    else if (rise && state_r == TGW_ST_CLAMP)
    begin
      unique case ({ctrl_r[TGW_DLY1_BIT], ctrl_r[TGW_DLY0_BIT]})
        2'b01:   target_r <= 5'(TGW_EDGES_EXT0);
        2'b11:   target_r <= 5'(TGW_EDGES_EXT1);
        default: target_r <= 5'(TGW_EDGES_NONE);
      endcase
    end
  end

  // divided-edge counter advances only on the divider pulse; the rise is not
  // aligned to it, so the real wait can be up to one divided period off
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || state_r != TGW_ST_WAIT_DIV)
      div_cnt_r <= '0;
    else if (tk_if.tick)
      div_cnt_r <= div_cnt_r + 5'd1;
  end

  // fixed converter-clock tail, full rate
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || state_r != TGW_ST_WAIT_FIX)
      fix_cnt_r <= '0;
    else
      fix_cnt_r <= fix_cnt_r + 4'd1;
  end

  // ==========================================================
  // converter outputs and power-down
  // clamp whenever not running, so the flush never reaches the outputs
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      i_out_r <= TGW_MIDSCALE;
      q_out_r <= TGW_MIDSCALE;
      act_r   <= 1'b1;
    end
    else
    begin
      i_out_r <= (state_r == TGW_ST_RUN) ? dac_i_in : TGW_MIDSCALE;
      q_out_r <= (state_r == TGW_ST_RUN) ? dac_q_in : TGW_MIDSCALE;
      act_r   <= (state_r == TGW_ST_RUN);
    end
  end

  // blocks sleep only while the pin is low; they are woken at the rise
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pd_r <= '0;
    else
      pd_r <= (state_r == TGW_ST_CLAMP) ? ctrl_r[TGW_PD_LSB +: TGW_PD_W] : '0;
  end

  assign dac_i_out = i_out_r;
  assign dac_q_out = q_out_r;
  assign tx_active = act_r;
  assign pd_out    = pd_r;

  // ==========================================================
  // avalon-mm slave: one wait cycle, then a one-cycle answer
  assign req = avs_read || avs_write;

  // waitrequest idles high and drops for exactly one cycle per request
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wait_r <= 1'b1;
    else
      wait_r <= !(req && wait_r);
  end

  // read data is ready when waitrequest drops; unmapped reads give zero
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rdata_r <= '0;
    else if (avs_read && wait_r)
    begin
      rdata_r <= '0;
      if (avs_address == TGW_OFS_CTRL)
        rdata_r[6:0] <= ctrl_r;
      else if (avs_address == TGW_OFS_STAT)
      begin
        rdata_r[TGW_ST_ACT_BIT]  <= act_r;
        rdata_r[TGW_ST_CLP_BIT]  <= (state_r == TGW_ST_CLAMP);
        rdata_r[TGW_ST_WAIT_BIT] <= (state_r == TGW_ST_WAIT_DIV) ||
                                    (state_r == TGW_ST_WAIT_FIX);
        rdata_r[TGW_ST_PIN_BIT]  <= pin_s2_r;
        rdata_r[TGW_ST_PD_LSB +: TGW_PD_W] <= pd_r;
        rdata_r[TGW_ST_CNT_LSB +: 5]       <= div_cnt_r;
      end
    end
  end

  // control write lands on the edge that sees waitrequest low; all fields
  // live in byte lane 0, so only that lane's enable matters
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ctrl_r <= TGW_CTRL_RST;
    else if (avs_write && !wait_r && avs_address == TGW_OFS_CTRL && avs_byteenable[0])
      ctrl_r <= avs_writedata[6:0];
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;

  // ==========================================================
  // helper: cycles since the last rise, for the wait bound
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || state_r == TGW_ST_CLAMP || state_r == TGW_ST_RUN)
      wake_cyc_r <= '0;
    else
      wake_cyc_r <= wake_cyc_r + 12'd1;
  end

  // ==========================================================
  // checks
  a_clamp_midscale: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !act_r |-> (i_out_r == TGW_MIDSCALE && q_out_r == TGW_MIDSCALE))
  else $error("outputs not at midscale while clamped");

  a_fall_clamps: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (fall && state_r == TGW_ST_RUN) |=> ##1 !act_r)
  else $error("falling edge did not clamp the outputs");

  a_pd_gated: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r != TGW_ST_CLAMP) |=> (pd_r == '0))
  else $error("block powered down outside the clamp");

  a_fix_tail: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == TGW_ST_WAIT_FIX && state_nxt == TGW_ST_RUN) |-> (fix_cnt_r == 4'(TGW_FIX_CYC - 1)))
  else $error("fixed tail not ten converter clocks");

  a_div_rate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == TGW_ST_WAIT_DIV && !tk_if.tick && !fall) |=> $stable(div_cnt_r))
  else $error("wake counter moved without a divided pulse");

  a_div_target: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == TGW_ST_WAIT_DIV ##1 state_r == TGW_ST_WAIT_FIX)
      |-> ($past(div_cnt_r) + 5'd1 == target_r))
  else $error("left divided wait at the wrong count");

  a_wake_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wake_cyc_r <= 12'(WAKE_MAX))
  else $error("wake-up wait ran past its bound");

  a_cold_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !primed_r |-> (state_r == TGW_ST_RUN))
  else $error("clamp before the pin was trusted");

  a_abort_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (fall && (state_r == TGW_ST_WAIT_DIV || state_r == TGW_ST_WAIT_FIX))
      |=> (state_r == TGW_ST_CLAMP) ##1 !act_r)
  else $error("fall during the wait did not return to clamp");

endmodule : tgw_gate

`default_nettype wire

// ==== verif/tgw_ctrl_model.sv ====
/*
  tgw_ctrl_model: system controller that drives the transmit gate pin.
  assumes: the bench requests pin levels on clk_sys; reset stands for power-up.
*/
`timescale 1ns/1ps
`default_nettype none

module tgw_ctrl_model (
  // power-up phase and scenario controls
  input  wire logic sys_rst,
  input  wire logic pin_req,
  input  wire logic bad_pwrup,
  // pin towards the device
  output logic      transmit_gate_pin
);
  // ==========================================================
  // pin drive
  // a real controller keeps the pin high while the part powers up;
  // bad_pwrup breaks that on purpose so the edge-only clamp can be seen
  always_comb
  begin
    if (sys_rst && !bad_pwrup)
    begin
      transmit_gate_pin = 1'b1;
    end
    else
    begin
      transmit_gate_pin = pin_req;
    end
  end
endmodule : tgw_ctrl_model

`default_nettype wire

// ==== verif/tgw_gate_tb.sv ====
/*
  tgw_gate_tb: self-checking bench for the transmit gate wake-up block.
  assumes: the controller model drives the pin; registers over avalon-mm.
*/
`timescale 1ns/1ps
`default_nettype none

module tgw_gate_tb;
  import tgw_pkg::*;

  // ==========================================================
  // signals
  logic        clk_sys, sys_rst;        // clock and reset
  logic [3:0]  avs_address;             // register bus
  logic        avs_read, avs_write;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest;
  logic        transmit_gate_pin;       // pin from the model
  logic        pin_req, bad_pwrup;      // model controls
  logic [15:0] dac_i_in, dac_q_in, dac_i_out, dac_q_out;
  logic        tx_active;
  logic [4:0]  pd_out;
  int          bad_count, checks_done;  // verdict counters
  // delay choices with a distinct power-down mask each
  localparam logic [6:0] DLY [3] = '{7'h00, 7'h20, 7'h60};
  localparam logic [4:0] MSK [3] = '{5'h15, 5'h0a, 5'h1f};
  localparam int         EDG [3] = '{TGW_EDGES_NONE, TGW_EDGES_EXT0, TGW_EDGES_EXT1};

  // ==========================================================
  // design and partner
  tgw_gate DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .transmit_gate_pin(transmit_gate_pin),
    .dac_i_in(dac_i_in), .dac_q_in(dac_q_in), .dac_i_out(dac_i_out),
    .dac_q_out(dac_q_out), .tx_active(tx_active), .pd_out(pd_out));
  tgw_ctrl_model ctrl (.sys_rst(sys_rst), .pin_req(pin_req), .bad_pwrup(bad_pwrup),
    .transmit_gate_pin(transmit_gate_pin));

  // ==========================================================
  // helpers
  // verdict and end of run, shared with the watchdog
  task automatic wrap_up;
    begin
      if (bad_count == 0 && checks_done > 0)
      begin
        $display("Test passed");
      end
      else
      begin
        $display("Test failed");
      end
      $finish;
    end
  endtask : wrap_up

  // exact value compare, four-state
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
      checks_done++;
      if (got !== exp)
      begin
        bad_count++;
        $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask : chk

  // cycle count within a window
  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    begin
      checks_done++;
      if (got < lo || got > hi)
      begin
        bad_count++;
        $display("Error %0t: %s took %0d not %0d..%0d", $time, what, got, lo, hi);
      end
    end
  endtask : chk_rng

  // one bus transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    int w;
    begin
      w = 0;
      @(posedge clk_sys);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do
      begin
        @(posedge clk_sys);
        w++;
      end
      while (avs_waitrequest !== 1'b0 && w < 50);
      chk({31'h0, avs_waitrequest}, 32'h0, "bus answer");
      if (!wr)
      begin
        chk(avs_readdata, exp, "read data");
      end
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
    end
  endtask : bus

  // pin falls: outputs clamp, selected blocks power down
  task automatic drop_pin(input logic [4:0] mask);
    begin
      @(posedge clk_sys);
      pin_req <= 1'b0;
      repeat (8) @(posedge clk_sys);
      chk({31'h0, tx_active}, 32'h0, "tx after fall");
      chk({16'h0, dac_i_out}, {16'h0, TGW_MIDSCALE}, "i clamp");
      chk({16'h0, dac_q_out}, {16'h0, TGW_MIDSCALE}, "q clamp");
      chk({27'h0, pd_out}, {27'h0, mask}, "power-down");
    end
  endtask : drop_pin

  // pin rises: time the wake-up, outputs must stay clamped meanwhile
  task automatic rise_pin(input int edges);
    int    n;
    logic  held;
    begin
      n    = 0;
      held = 1'b1;
      @(posedge clk_sys);
      pin_req <= 1'b1;
      while (tx_active !== 1'b1 && n < 3000)
      begin
        @(posedge clk_sys);
        n++;
        if (tx_active !== 1'b1 && (dac_i_out !== TGW_MIDSCALE || dac_q_out !== TGW_MIDSCALE))
        begin
          held = 1'b0;
        end
      end
      chk({31'h0, held}, 32'h1, "clamp in wait");
      // edges run on the divided clock, may be one short, then the fixed ten
      chk_rng(n, (edges - 1) * TGW_DIV_RATIO + TGW_FIX_CYC + 1,
              edges * TGW_DIV_RATIO + TGW_FIX_CYC + 8, "wake");
      chk({27'h0, pd_out}, 32'h0, "power-up after wait");
      @(posedge clk_sys);
      chk({16'h0, dac_i_out}, {16'h0, dac_i_in}, "i data");
      chk({16'h0, dac_q_out}, {16'h0, dac_q_in}, "q data");
    end
  endtask : rise_pin

  // ==========================================================
  // clock and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // the tests need under 8000 cycles
  initial
  begin
    #(4 * 20000);
    bad_count++;
    wrap_up;
  end

  // ==========================================================
  // tests
  initial
  begin
    sys_rst = 1'b1; pin_req = 1'b0; bad_pwrup = 1'b1;
    avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0; avs_byteenable = 4'hf;
    dac_i_in = 16'h1234; dac_q_in = 16'hedcb;
    bad_count = 0; checks_done = 0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // pin low through power-up: no edge, so no clamp
    repeat (20) @(posedge clk_sys);
    chk({31'h0, tx_active}, 32'h1, "level clamp");
    chk({16'h0, dac_i_out}, {16'h0, dac_i_in}, "i pass");
    pin_req   <= 1'b1;
    bad_pwrup <= 1'b0;
    bus(1'b0, TGW_OFS_CTRL, 32'h0, {25'h0, TGW_CTRL_RST});
    bus(1'b0, 4'h8, 32'h0, 32'h0);
    // every delay choice, long enough for the masked blocks
    for (int k = 0; k < 3; k++)
    begin
      bus(1'b1, TGW_OFS_CTRL, {25'h0, DLY[k] | {2'b00, MSK[k]}}, 32'h0);
      bus(1'b0, TGW_OFS_CTRL, 32'h0, {25'h0, DLY[k] | {2'b00, MSK[k]}});
      drop_pin(MSK[k]);
      bus(1'b0, TGW_OFS_STAT, 32'h0, (32'h1 << TGW_ST_CLP_BIT) | ({27'h0, MSK[k]} << TGW_ST_PD_LSB));
      rise_pin(EDG[k]);
      bus(1'b0, TGW_OFS_STAT, 32'h0, (32'h1 << TGW_ST_ACT_BIT) | (32'h1 << TGW_ST_PIN_BIT));
    end
    // fall in mid-wait abandons the count; next rise starts it afresh
    drop_pin(MSK[2]);
    @(posedge clk_sys);
    pin_req <= 1'b1;
    repeat (300) @(posedge clk_sys);
    pin_req <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk({31'h0, tx_active}, 32'h0, "abort clamp");
    chk({27'h0, pd_out}, {27'h0, MSK[2]}, "abort power-down");
    rise_pin(EDG[2]);
    wrap_up;
  end
endmodule : tgw_gate_tb

`default_nettype wire
